// *** rtl/async_waveform_timer.sv ***
// control, crossing and compare front end of the 12-bit waveform timer
//
// Notes on behaviour
// - core runs from its own clock source; compare values cross into it
// - two compare units drive outputs one and two; three and four mirror
// - counter compared against compare values each counter tick, events
// - each input event has its own mode; mode decides outputs and jump
// - clock source chosen by control_first: rc oscillator, external, system
// - debug halt stops the core unless the debug run bit is set
// - debug fault bit with halt raises fault on both event inputs
// - writing enable 0 stops the core once crossed into it
// - disable-at-end strobe stops the core at the cycle boundary
// - control_first fields other than enable change only while disabled
// - enable changes accepted only while enable ready reads 1
// - commands cross when enabled and idle; software waits command ready
// - command bits clear themselves once their action is done
// - sync-at-end loads all buffered registers at the cycle boundary
// - sync loads all buffered registers as soon as it has crossed
// - restart sends the counter back to cycle start
// - software capture copies counter into capture first or second
// - buffered registers written while ready; loaded on sync or enable
// - static registers ignore writes while enable reads 1
// - status, capture and interrupt registers need no crossing
// - registers grouped as buffered, static, read-only and normal
// - the selected clock source feeds a sync prescaler, which feeds the counter and delay prescalers; each has its own setting
// - counter division is sync prescale times counter prescale
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps

module async_waveform_timer (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source pins
  input wire logic internal_rc_oscillator,
  input wire logic ext_clock_in,
  // event system and debug
  input wire logic event_in_first,
  input wire logic event_in_second,
  input wire logic cpu_debug_halted,
  // waveform outputs and events
  output logic waveform_out_first,
  output logic waveform_out_second,
  output logic waveform_out_third,
  output logic waveform_out_fourth,
  output logic cmp_a_event,
  output logic cmp_b_event,
  output logic cycle_end_event,
  output logic delay_clock_tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [11:0] ctrl_a;
    logic [awt_pkg::N_STAT-1:0][7:0] stat;
    logic [awt_pkg::N_DBUF-1:0][awt_pkg::CW-1:0] dbuf;
    logic [awt_pkg::N_DBUF-1:0][awt_pkg::CW-1:0] core;
    logic en_pend;
    logic [7:0] cmd;
    logic cmd_cross;
    logic [1:0] xcnt;
    logic core_en;
    logic [awt_pkg::CW-1:0] cnt;
    logic [2:0] spc;
    logic [2:0] cpc;
    logic [2:0] dpc;
    logic [awt_pkg::CW-1:0] cap_a;
    logic [awt_pkg::CW-1:0] cap_b;
    logic [7:0] int_ctrl;
    logic [7:0] int_flags;
    logic [2:0] rc_s;
    logic [2:0] ext_s;
    logic [1:0][2:0] ev_s;
    logic [3:0] wo;
    logic [2:0] evo;
    logic dly_tick;
    logic [31:0] prdata;
  } state_s;

  state_s q;
  state_s n;
  logic [4:0] idx;
  logic hit;
  logic wr;
  logic src_edge;
  logic sync_tick;
  logic cnt_tick;
  logic arrive;
  logic run;
  logic cyc_end;
  logic en_rdy;
  logic cmd_rdy;
  logic [1:0] ev_lvl;

  // divide mask for a two-bit power-of-two prescale setting
  function automatic logic [2:0] div_mask(input logic [1:0] f);
    div_mask = 3'((4'h1 << f) - 4'h1);
  endfunction : div_mask

  // register read mux, sampled in the setup phase
  function automatic logic [31:0] rd_word(input state_s s, input logic [4:0] i,
                                          input logic er, input logic cr,
                                          input logic rn);
    rd_word = 32'h0000_0000;
    if (i == awt_pkg::IDX_CTRL_A) begin
      rd_word[11:0] = s.ctrl_a;
      rd_word[awt_pkg::EN_BIT] = s.en;
    end else if (i >= awt_pkg::IDX_STAT0 && i < awt_pkg::IDX_DBUF0) begin
      rd_word[7:0] = s.stat[3'(i - awt_pkg::IDX_STAT0)];
    end else if (i >= awt_pkg::IDX_DBUF0 && i < awt_pkg::IDX_CMD) begin
      rd_word[11:0] = s.dbuf[4'(i - awt_pkg::IDX_DBUF0)];
    end else begin
      unique case (i)
        awt_pkg::IDX_CMD: rd_word[7:0] = s.cmd;
        awt_pkg::IDX_STATUS: rd_word[2:0] = {rn, cr, er};
        awt_pkg::IDX_CAP_A: rd_word[11:0] = s.cap_a;
        awt_pkg::IDX_CAP_B: rd_word[11:0] = s.cap_b;
        awt_pkg::IDX_INT_CTRL: rd_word[7:0] = s.int_ctrl;
        awt_pkg::IDX_INT_FLAGS: rd_word[7:0] = s.int_flags;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  endfunction : rd_word

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // the core domain is modelled as enable pulses from the selected source,
  // so the crossing latency is counted in sync ticks rather than in flops
  always_comb begin
    n = q;
    n.evo = 3'h0;
    n.dly_tick = 1'b0;
    idx = paddr[6:2];
    hit = paddr[1:0] == 2'h0 && paddr[11:7] == 5'h00
          && idx <= awt_pkg::IDX_INT_FLAGS;
    wr = psel && penable && pwrite && hit;
    en_rdy = !q.en_pend;
    cmd_rdy = q.cmd == 8'h00;
    // pin synchronisers; only the second and third flops are read
    n.rc_s = {q.rc_s[1:0], internal_rc_oscillator};
    n.ext_s = {q.ext_s[1:0], ext_clock_in};
    n.ev_s[0] = {q.ev_s[0][1:0], event_in_first};
    n.ev_s[1] = {q.ev_s[1][1:0], event_in_second};
    // clock source select
    unique case (q.ctrl_a[awt_pkg::CSEL_LSB+:2])
      awt_pkg::CLK_RC: src_edge = q.rc_s[1] & ~q.rc_s[2];
      awt_pkg::CLK_EXT: src_edge = q.ext_s[1] & ~q.ext_s[2];
      awt_pkg::CLK_SYS: src_edge = 1'b1;
      default: src_edge = 1'b1;
    endcase
    // sync prescaler feeds both the counter and the delay prescalers
    sync_tick = src_edge
      && q.spc == div_mask(q.ctrl_a[awt_pkg::SPSC_LSB+:2]);
    cnt_tick = sync_tick
      && q.cpc == div_mask(q.ctrl_a[awt_pkg::CPSC_LSB+:2]);
    if (src_edge) begin
      n.spc = sync_tick ? 3'h0 : q.spc + 3'h1;
    end
    if (sync_tick) begin
      n.cpc = cnt_tick ? 3'h0 : q.cpc + 3'h1;
      if (q.dpc == div_mask(
          q.core[awt_pkg::DB_DLY_CTRL][awt_pkg::DPSC_LSB+:2])) begin
        n.dpc = 3'h0;
        n.dly_tick = 1'b1;
      end else begin
        n.dpc = q.dpc + 3'h1;
      end
    end
    // debug halt gates the core unless told to run on
    run = q.core_en && (!cpu_debug_halted
          || q.core[awt_pkg::DB_DBG][awt_pkg::DBG_RUN]);
    for (int c = 0; c < 2; c++) begin
      ev_lvl[c] = q.ev_s[c][1] | (cpu_debug_halted
        & q.core[awt_pkg::DB_DBG][awt_pkg::DBG_FAULT]);
    end
    cyc_end = run && cnt_tick && q.cnt == q.core[awt_pkg::DB_B_CLR];

    // ---------------- bus writes ----------------
    if (wr && idx == awt_pkg::IDX_CTRL_A) begin
      if (!q.en) begin
        n.ctrl_a = pwdata[11:0] & ~12'h001;
      end
      if (en_rdy && pwdata[awt_pkg::EN_BIT] != q.en) begin
        n.en = pwdata[awt_pkg::EN_BIT];
        n.en_pend = 1'b1;
        n.cmd = 8'h00;
        n.cmd_cross = 1'b0;
      end
    end
    if (wr && !q.en && idx >= awt_pkg::IDX_STAT0
        && idx < awt_pkg::IDX_DBUF0) begin
      n.stat[3'(idx - awt_pkg::IDX_STAT0)] = pwdata[7:0];
    end
    if (wr && cmd_rdy && idx >= awt_pkg::IDX_DBUF0
        && idx < awt_pkg::IDX_CMD) begin
      n.dbuf[4'(idx - awt_pkg::IDX_DBUF0)] = pwdata[11:0];
    end
    if (wr && idx == awt_pkg::IDX_CMD && q.core_en && cmd_rdy && en_rdy
        && pwdata[7:0] != 8'h00) begin
      n.cmd = pwdata[7:0];
      n.cmd_cross = 1'b1;
    end
    if (wr && idx == awt_pkg::IDX_INT_CTRL) begin
      n.int_ctrl = pwdata[7:0];
    end
    if (wr && idx == awt_pkg::IDX_INT_FLAGS) begin
      n.int_flags = q.int_flags & ~pwdata[7:0]; // sets below win
    end

    // ---------------- crossing into the core ----------------
    arrive = sync_tick && (q.en_pend || q.cmd_cross)
             && q.xcnt == awt_pkg::SYNC_LAST;
    if (sync_tick && (q.en_pend || q.cmd_cross)) begin
      n.xcnt = arrive ? 2'h0 : q.xcnt + 2'h1;
    end
    if (arrive && q.en_pend) begin
      n.en_pend = 1'b0;
      n.core_en = q.en;
      n.cnt = '0;
      n.wo[1:0] = 2'h0;
      if (q.en) begin
        n.core = q.dbuf;
      end
    end
    if (arrive && q.cmd_cross) begin
      n.cmd_cross = 1'b0;
    end

    // ---------------- counter and compare ----------------
    if (run && cnt_tick) begin
      n.cnt = cyc_end ? '0 : q.cnt + 12'h001;
      if (q.cnt == q.core[awt_pkg::DB_A_SET]) begin
        n.wo[0] = 1'b1;
        n.evo[0] = 1'b1;
        n.int_flags[awt_pkg::INT_TRIG_A] = 1'b1;
      end
      if (q.cnt == q.core[awt_pkg::DB_A_CLR]) begin
        n.wo[0] = 1'b0;
      end
      if (q.cnt == q.core[awt_pkg::DB_B_SET]) begin
        n.wo[1] = 1'b1;
        n.evo[1] = 1'b1;
        n.int_flags[awt_pkg::INT_TRIG_B] = 1'b1;
      end
      if (cyc_end) begin
        n.wo[1] = 1'b0;
        n.evo[2] = 1'b1;
        n.int_flags[awt_pkg::INT_OVF] = 1'b1;
      end
    end

    // ---------------- live commands ----------------
    // a command acts only once it has crossed; bits clear as they finish
    if (q.core_en && !q.cmd_cross && q.cmd != 8'h00) begin
      n.cmd[awt_pkg::CMD_SYNC] = 1'b0;
      n.cmd[awt_pkg::CMD_RESTART] = 1'b0;
      n.cmd[awt_pkg::CMD_CAP_A] = 1'b0;
      n.cmd[awt_pkg::CMD_CAP_B] = 1'b0;
      if (q.cmd[awt_pkg::CMD_SYNC]) begin
        n.core = q.dbuf;
      end
      if (q.cmd[awt_pkg::CMD_RESTART]) begin
        n.cnt = '0;
        n.wo[1:0] = 2'h0;
      end
      if (q.cmd[awt_pkg::CMD_CAP_A]) begin
        n.cap_a = q.cnt;
      end
      if (q.cmd[awt_pkg::CMD_CAP_B]) begin
        n.cap_b = q.cnt;
      end
      if (cyc_end) begin
        n.cmd[awt_pkg::CMD_SYNC_EOC] = 1'b0;
        n.cmd[awt_pkg::CMD_DIS_EOC] = 1'b0;
        if (q.cmd[awt_pkg::CMD_SYNC_EOC]) begin
          n.core = q.dbuf;
        end
        if (q.cmd[awt_pkg::CMD_DIS_EOC]) begin
          n.core_en = 1'b0;
          n.en = 1'b0;
          n.cnt = '0;
          n.wo[1:0] = 2'h0;
        end
      end
    end

    // ---------------- input events ----------------
    for (int c = 0; c < 2; c++) begin
      if (ev_lvl[c] && q.stat[awt_pkg::ST_EV_A + c][awt_pkg::EV_TRIG]
          && q.stat[awt_pkg::ST_IN_A + c][3:0] != 4'h0) begin
        n.wo[c] = 1'b0;
        if (q.stat[awt_pkg::ST_IN_A + c][0] && run && cnt_tick) begin
          n.cnt = '0;
        end
      end
      if (run && q.ev_s[c][1] && !q.ev_s[c][2]
          && q.stat[awt_pkg::ST_EV_A + c][awt_pkg::EV_ACTION]) begin
        if (c == 0) begin
          n.cap_a = q.cnt;
        end else begin
          n.cap_b = q.cnt;
        end
      end
    end
    if (!q.core_en) begin
      n.wo[1:0] = 2'h0;
    end
    // mirrors take the units' next values, so they switch in the same cycle as the units
    n.wo[2] = q.stat[awt_pkg::ST_CTRL_B][0] ? n.wo[1] : n.wo[0];
    n.wo[3] = q.stat[awt_pkg::ST_CTRL_B][1] ? n.wo[1] : n.wo[0];

    // read data is captured in the setup phase, answer is zero wait
    if (psel && !penable) begin
      n.prdata = rd_word(q, idx, en_rdy, cmd_rdy, q.core_en);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign waveform_out_first = q.wo[0];
  assign waveform_out_second = q.wo[1];
  assign waveform_out_third = q.wo[2];
  assign waveform_out_fourth = q.wo[3];
  assign cmp_a_event = q.evo[0];
  assign cmp_b_event = q.evo[1];
  assign cycle_end_event = q.evo[2];
  assign delay_clock_tick = q.dly_tick;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_static_wr;
    wr && q.en && idx == awt_pkg::IDX_STAT0;
  endsequence
  sequence s_en_take;
    wr && idx == awt_pkg::IDX_CTRL_A && en_rdy
    && pwdata[awt_pkg::EN_BIT] != q.en;
  endsequence

  AST_STATIC_FROZEN: assert property (@(posedge clock) disable iff (!arst_n)
    s_static_wr |=> $stable(q.stat)) else $error("static written");
  AST_EN_RDY_DROP: assert property (@(posedge clock) disable iff (!arst_n)
    s_en_take |=> !en_rdy ##0 q.en == $past(pwdata[0]))
    else $error("enable ready did not drop");
  AST_EN_BUSY: assert property (@(posedge clock) disable iff (!arst_n)
    wr && idx == awt_pkg::IDX_CTRL_A && !en_rdy |=> $stable(q.en))
    else $error("enable changed while busy");
  AST_DISABLE: assert property (@(posedge clock) disable iff (!arst_n)
    arrive && q.en_pend && !q.en |=> !q.core_en && q.wo[1:0] == 2'h0)
    else $error("disable did not stop core");
  AST_WRAP: assert property (@(posedge clock) disable iff (!arst_n)
    cyc_end && !q.stat[awt_pkg::ST_IN_A][0] |=> q.cnt == '0 && cycle_end_event)
    else $error("cycle end missed");
  AST_HALT: assert property (@(posedge clock) disable iff (!arst_n)
    cpu_debug_halted && !q.core[awt_pkg::DB_DBG][awt_pkg::DBG_RUN]
    && !q.en_pend && !(q.core_en && q.cmd != 8'h00) |=> $stable(q.cnt))
    else $error("core ran during halt");
  AST_DIS_EOC: assert property (@(posedge clock) disable iff (!arst_n)
    cyc_end && !q.cmd_cross && q.cmd[awt_pkg::CMD_DIS_EOC]
    |=> !q.core_en && !q.en && !q.cmd[awt_pkg::CMD_DIS_EOC])
    else $error("end of cycle disable missed");
  AST_SYNC_LOAD: assert property (@(posedge clock) disable iff (!arst_n)
    q.core_en && !q.cmd_cross && q.cmd[awt_pkg::CMD_SYNC]
    |=> q.core == $past(q.dbuf) && !q.cmd[awt_pkg::CMD_SYNC])
    else $error("sync did not load");
  AST_DBG_FAULT: assert property (@(posedge clock) disable iff (!arst_n)
    cpu_debug_halted && q.core[awt_pkg::DB_DBG][awt_pkg::DBG_FAULT]
    && q.stat[awt_pkg::ST_EV_A][awt_pkg::EV_TRIG]
    && q.stat[awt_pkg::ST_IN_A][3:0] != 4'h0 |=> !waveform_out_first)
    else $error("debug fault did not force");
  AST_CMD_WAIT: assert property (@(posedge clock) disable iff (!arst_n)
    wr && idx == awt_pkg::IDX_CMD && !cmd_rdy && q.cmd_cross
    |=> $stable(q.cmd)) else $error("command taken while busy");

endmodule : async_waveform_timer

// *** include/awt_pkg.sv ***
// constants, register map and field layout of the waveform timer front end
package awt_pkg;

  // ---------------------------------------------------------------
  // widths and crossing depth
  // ---------------------------------------------------------------
  localparam int CW = 12;
  localparam int N_STAT = 8;
  localparam int N_DBUF = 9;
  localparam logic [1:0] SYNC_LAST = 2'h1; // two ticks of the sync clock

  // ---------------------------------------------------------------
  // register word indices (byte address is index times four)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL_A = 5'h00;
  localparam logic [4:0] IDX_STAT0 = 5'h01;
  localparam logic [4:0] IDX_DBUF0 = 5'h09;
  localparam logic [4:0] IDX_CMD = 5'h12;
  localparam logic [4:0] IDX_STATUS = 5'h13;
  localparam logic [4:0] IDX_CAP_A = 5'h14;
  localparam logic [4:0] IDX_CAP_B = 5'h15;
  localparam logic [4:0] IDX_INT_CTRL = 5'h16;
  localparam logic [4:0] IDX_INT_FLAGS = 5'h17;

  // slots of the static and double-buffered groups
  localparam int ST_CTRL_B = 0;
  localparam int ST_EV_A = 3;
  localparam int ST_IN_A = 5;
  localparam int DB_DLY_CTRL = 0;
  localparam int DB_DBG = 4;
  localparam int DB_A_SET = 5;
  localparam int DB_A_CLR = 6;
  localparam int DB_B_SET = 7;
  localparam int DB_B_CLR = 8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EN_BIT = 0;
  localparam int SPSC_LSB = 3;
  localparam int CSEL_LSB = 5;
  localparam int CPSC_LSB = 8;
  localparam int DPSC_LSB = 4;
  localparam int CMD_SYNC_EOC = 0;
  localparam int CMD_SYNC = 1;
  localparam int CMD_RESTART = 2;
  localparam int CMD_CAP_A = 3;
  localparam int CMD_CAP_B = 4;
  localparam int CMD_DIS_EOC = 7;
  localparam int DBG_RUN = 0;
  localparam int DBG_FAULT = 2;
  localparam int EV_TRIG = 0;
  localparam int EV_ACTION = 2;
  localparam int INT_OVF = 0;
  localparam int INT_TRIG_A = 2;
  localparam int INT_TRIG_B = 3;

  // clock source codes
  localparam logic [1:0] CLK_RC = 2'h0;
  localparam logic [1:0] CLK_EXT = 2'h1;
  localparam logic [1:0] CLK_SYS = 2'h2;

endpackage : awt_pkg

// *** tb/power_stage_model.sv ***
// model of the power stage hanging on the first two waveform outputs
`timescale 1ns/1ps

module power_stage_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // gate drives
  input wire logic high_gate,
  input wire logic low_gate,
  // observations
  output logic [11:0] on_len,
  output logic shoot
);
  logic [11:0] run_q;

  // conduction time of the high switch, kept per finished pulse;
  // both switches on at once would short the supply rail
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 12'h000;
      on_len <= 12'h000;
      shoot <= 1'b0;
    end else begin
      run_q <= high_gate ? run_q + 12'h001 : 12'h000;
      if (!high_gate && run_q != 12'h000) on_len <= run_q;
      if (high_gate && low_gate) shoot <= 1'b1;
    end
  end
endmodule : power_stage_model

// *** tb/testbench.sv ***
// self-checking bench for the waveform timer front end
`timescale 1ns/1ps

module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rc_osc, ext_clk, ev_a, ev_b, halted, mir_bad, shoot;
  logic wo_a, wo_b, wo_c, wo_d, cmp_a, cmp_b, ev_end, dly_tick;
  logic [11:0] on_len;
  int miscompares, n_compared, cyc, last_end, period, ends, hi_cnt;
  int h0, e0, n_ca, n_cb, n_dt;

  async_waveform_timer i_async_waveform_timer (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_rc_oscillator(rc_osc),
    .ext_clock_in(ext_clk), .event_in_first(ev_a),
    .event_in_second(ev_b), .cpu_debug_halted(halted),
    .waveform_out_first(wo_a), .waveform_out_second(wo_b),
    .waveform_out_third(wo_c), .waveform_out_fourth(wo_d),
    .cmp_a_event(cmp_a), .cmp_b_event(cmp_b), .cycle_end_event(ev_end),
    .delay_clock_tick(dly_tick));

  power_stage_model i_power_stage_model (
    .clock(clock), .arst_n(arst_n), .high_gate(wo_a), .low_gate(wo_b),
    .on_len(on_len), .shoot(shoot));

  // ---------------------------------------------------------------
  // clocks, monitors and timeout
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // free-running rc source, slower than half the system clock
  initial begin
    rc_osc = 1'b0;
    forever #75 rc_osc = ~rc_osc;
  end

  // cycle length from cycle-end pulses, high time of the first output
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wo_a) hi_cnt <= hi_cnt + 1;
    if (cmp_a) n_ca <= n_ca + 1;
    if (cmp_b) n_cb <= n_cb + 1;
    if (dly_tick) n_dt <= n_dt + 1;
    if (ev_end) begin
      period <= cyc - last_end;
      last_end <= cyc;
      ends <= ends + 1;
    end
    if (cyc > 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // third follows second, fourth follows first with control_second = 1
  always @(negedge clock) begin
    if (arst_n && (wo_c !== wo_b || wo_d !== wo_a)) mir_bad <= 1'b1;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded poll of one bit; caller compares the final read
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === v) break;
    end
  endtask : poll

  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(n, rd, exp);
  endtask : rdchk

  // waits for command ready, issues one strobe, waits for it to clear
  task automatic cmd(input int b);
    poll(12'h04c, 1, 1'b1);
    apb(1'b1, 12'h048, 32'h1 << b);
    poll(12'h048, b, 1'b0);
    chk("command", rd, 32'h0);
  endtask : cmd

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, ev_a, ev_b, halted, mir_bad} = '0;
    ext_clk = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {miscompares, n_compared, cyc, last_end, period, ends, hi_cnt} = '0;
    {n_ca, n_cb, n_dt} = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, 12'h04c, 32'h0);
    chk("enable_ready", {31'h0, rd[0]}, 32'h1);
    rdchk("control_first", 12'h000, 32'h0);
    apb(1'b1, 12'h060, 32'h1);
    chk("unmapped error", {31'h0, err}, 32'h1);
    // static setup, then compare values 2/4/6/9
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h018, 32'h2);
    apb(1'b1, 12'h000, 32'h40);
    rdchk("control_first", 12'h000, 32'h40);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h038 + 12'(4 * i), 32'(i * 2 + 2 + (i / 3)));
    end
    rdchk("b_clear", 12'h044, 32'h9);
    poll(12'h04c, 0, 1'b1);
    apb(1'b1, 12'h000, 32'h41);
    poll(12'h04c, 2, 1'b1);
    chk("running", {31'h0, rd[2]}, 32'h1);
    repeat (40) @(posedge clock);
    chk("cycle length", period, 32'd10);
    chk("on time", 32'(on_len), 32'd2);
    chk("overlap", {31'h0, shoot}, 32'h0);
    chk("compare events", 32'(n_ca > 0 && n_cb > 0), 32'h1);
    chk("delay tick", 32'(n_dt > 0), 32'h1);
    // frozen settings while enabled
    apb(1'b1, 12'h004, 32'h0);
    rdchk("control_second", 12'h004, 32'h1);
    apb(1'b1, 12'h000, 32'h21);
    rdchk("control_first", 12'h000, 32'h41);
    // buffered value waits for a sync, both sync kinds
    poll(12'h04c, 1, 1'b1);
    apb(1'b1, 12'h03c, 32'h7);
    repeat (30) @(posedge clock);
    chk("on time held", 32'(on_len), 32'd2);
    cmd(awt_pkg::CMD_SYNC);
    repeat (30) @(posedge clock);
    chk("on time sync", 32'(on_len), 32'd5);
    poll(12'h04c, 1, 1'b1);
    apb(1'b1, 12'h03c, 32'h4);
    cmd(awt_pkg::CMD_SYNC_EOC);
    repeat (30) @(posedge clock);
    chk("on time eoc", 32'(on_len), 32'd2);
    // restart and software captures
    cmd(awt_pkg::CMD_RESTART);
    cmd(awt_pkg::CMD_CAP_A);
    apb(1'b0, 12'h050, 32'h0);
    chk("capture_first upper", rd & 32'hffff_f000, 32'h0);
    chk("capture_first range", 32'(rd <= 32'h9), 32'h1);
    cmd(awt_pkg::CMD_CAP_B);
    apb(1'b0, 12'h054, 32'h0);
    chk("capture_second range", 32'(rd <= 32'h9), 32'h1);
    // input event holds the first output low
    ev_a <= 1'b1;
    repeat (6) @(posedge clock);
    h0 = hi_cnt;
    repeat (40) @(posedge clock);
    chk("event forced", hi_cnt - h0, 32'h0);
    ev_a <= 1'b0;
    // debug halt stops the core, then run with forced fault
    halted <= 1'b1;
    repeat (6) @(posedge clock);
    e0 = ends;
    repeat (40) @(posedge clock);
    chk("halted ends", ends - e0, 32'h0);
    halted <= 1'b0;
    poll(12'h04c, 1, 1'b1);
    apb(1'b1, 12'h034, 32'h5);
    cmd(awt_pkg::CMD_SYNC);
    halted <= 1'b1;
    repeat (6) @(posedge clock);
    e0 = ends;
    h0 = hi_cnt;
    repeat (40) @(posedge clock);
    chk("debug run", 32'(ends > e0), 32'h1);
    chk("debug fault", hi_cnt - h0, 32'h0);
    halted <= 1'b0;
    apb(1'b0, 12'h05c, 32'h0);
    chk("cycle end flag", {31'h0, rd[0]}, 32'h1);
    // disable at end of cycle, then enable and plain disable
    cmd(awt_pkg::CMD_DIS_EOC);
    poll(12'h04c, 2, 1'b0);
    chk("stopped", {31'h0, rd[2]}, 32'h0);
    rdchk("control_first", 12'h000, 32'h40);
    apb(1'b1, 12'h05c, 32'hd);
    rdchk("flags", 12'h05c, 32'h0);
    apb(1'b1, 12'h000, 32'h41);
    poll(12'h04c, 2, 1'b1);
    poll(12'h04c, 0, 1'b1);
    apb(1'b1, 12'h000, 32'h40);
    poll(12'h04c, 2, 1'b0);
    chk("disabled", {31'h0, rd[2]}, 32'h0);
    chk("mirrors", {31'h0, mir_bad}, 32'h0);
    apb(1'b1, 12'h004, 32'h2);
    rdchk("control_second", 12'h004, 32'h2);
    wrap_up();
  end
endmodule : testbench
